/* rtl/msr_map.svh */
// constants for the main speed ramp and quick stop block
// assumes a 100 MHz mclk and percent values in hundredths (0..10000)
`ifndef MSR_MAP_SVH
`define MSR_MAP_SVH
`define MSR_ADDR_KEYPAD 4'h0
`define MSR_ADDR_SOURCE 4'h1
`define MSR_ADDR_RAMP_EN 4'h2
`define MSR_ADDR_UP_TIME 4'h3
`define MSR_ADDR_DOWN_TIME 4'h4
`define MSR_ADDR_QSTOP_TIME 4'h5
`define MSR_ADDR_DIN_FUNC 4'h6
`define MSR_ADDR_DISPLAY 4'h7
`define MSR_ADDR_STATUS 4'h8
`define MSR_PCT_MAX 14'h2710
`define MSR_KEYPAD_RST 14'h0000
`define MSR_UP_TIME_RST 12'h064
`define MSR_DOWN_TIME_RST 12'h0C8
`define MSR_QSTOP_TIME_RST 12'h01E
`define MSR_TIME_MAX 12'hBB8
`define MSR_QSTOP_TIME_MIN 12'h001
`define MSR_SRC_MAX 4'h8
`define MSR_FUNC_QSTOP 6'h32
`define MSR_TENTH_SCALE 4'hA
`define MSR_TICK_NS 32'h000F4240
`define MSR_CLK_NS 32'h0000000A
`define MSR_TICK_CYCLES (`MSR_TICK_NS / `MSR_CLK_NS)
`define MSR_TICKS_PER_TENTH 32'h00000064
`define MSR_ACC_FRAC 16
`endif

/* rtl/msr_pkg.sv */
// types for the main speed ramp and quick stop block
// enum codes are set here; assumes msr_map.svh supplies the other numbers
package msr_pkg;
    typedef enum logic [3:0] {
        MSR_SRC_KEYPAD = 4'h0,
        MSR_SRC_VOLT_A = 4'h1,
        MSR_SRC_CURR_A = 4'h2,
        MSR_SRC_VOLT_B = 4'h3,
        MSR_SRC_CURR_B = 4'h4,
        MSR_SRC_SERIAL = 4'h5,
        MSR_SRC_ENCODER = 4'h6,
        MSR_SRC_FIELDBUS = 4'h7,
        MSR_SRC_CONTROLLER = 4'h8
    } msr_src_t;
    typedef enum logic [1:0] {
        MSR_ST_IDLE = 2'b00,
        MSR_ST_RUN = 2'b01,
        MSR_ST_QSTOP = 2'b10
    } msr_state_t;
endpackage

/* rtl/msr_ramp.sv */
// main speed reference: source select, ramp, quick stop, tension scaling
// assumes synchronous inputs on mclk and a one-cycle register port
// What this block does
// - pick speed from one of nine sources
// - keypad speed 0.00 to 100.00, reset zero
// - keypad source uses stored keypad speed
// - serial, fieldbus, controller inputs are tenths
// - ramp enabled moves output at set rates
// - ramp disabled applies target at once
// - ramp up time 0..300 s, reset 10
// - ramp down time 0..300 s, reset 20
// - ramp times refer to full 100 percent
// - display target stopped, ramped speed running
// - input function code 50 means quick stop
// - quick stop decelerates over fixed time
// - quick stop time 0.1..300 s, reset 3
// - output and tension loop stay active
// - closed loop tension is sensor percent
// - open loop tension is torque percent
// - speed is percent of max line speed
`include "msr_map.svh"
module msr_ramp
    import msr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic run_cmd,
    input wire logic [7:0] din,
    input wire logic [13:0] voltage_in_a,
    input wire logic [13:0] current_in_a,
    input wire logic [13:0] voltage_in_b,
    input wire logic [13:0] current_in_b,
    input wire logic [13:0] encoder_in,
    input wire logic [15:0] serial_in,
    input wire logic [15:0] fieldbus_in,
    input wire logic [15:0] controller_card_source,
    input wire logic closed_loop,
    input wire logic [13:0] tension_cmd,
    output logic [13:0] main_speed,
    output logic [13:0] main_speed_disp,
    output logic drive_out_en,
    output logic tension_reg_en,
    output logic quick_stop_active,
    output logic tension_is_force,
    output logic [13:0] tension_pct
);
    localparam int TICK_CYC = `MSR_TICK_CYCLES;

    logic [13:0] keypad_r;
    msr_src_t src_r;
    logic speed_ramp_enable_r;
    logic [11:0] speed_ramp_up_time_r;
    logic [11:0] speed_ramp_down_time_r;
    logic [11:0] qstop_time_r;
    logic [5:0] digital_input_function_r [8];
    msr_state_t state_r;
    logic [16:0] tick_cnt_r;
    logic tick_r;
    logic [13:0] target;
    logic [13:0] out_r;
    logic [29:0] acc_r;
    logic [29:0] step_q_r;
    logic [29:0] up_step;
    logic [29:0] down_step;
    logic [29:0] target_acc;
    logic [29:0] qstop_step;
    logic qstop_in;
    logic [7:0] qstop_hit;

    // tenths of percent to hundredths, clamped to full scale
    function automatic logic [13:0] tenths_to_pct(input logic [15:0] v);
        logic [19:0] p;
        p = 20'(v) * 20'(`MSR_TENTH_SCALE);
        if (p > 20'(`MSR_PCT_MAX)) begin
            tenths_to_pct = `MSR_PCT_MAX;
        end else begin
            tenths_to_pct = p[13:0];
        end
    endfunction

    // clamp a written percent or time to its range
    function automatic logic [13:0] clamp14(input logic [15:0] v,
                                            input logic [13:0] hi);
        clamp14 = (v > 16'(hi)) ? hi : v[13:0];
    endfunction

    // per-tick step in 2^-16 units: full scale over time in ticks
    function automatic logic [29:0] step_of(input logic [11:0] t);
        logic [31:0] ticks;
        ticks = 32'(t) * `MSR_TICKS_PER_TENTH;
        if (t == 12'h000) begin
            step_of = {`MSR_PCT_MAX, 16'h0000};
        end else begin
            step_of = 30'(({18'h0, `MSR_PCT_MAX} << `MSR_ACC_FRAC) / ticks);
        end
    endfunction

    // quick stop function decode per input
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_din
            assign qstop_hit[gi] = din[gi] &&
                (digital_input_function_r[gi] == `MSR_FUNC_QSTOP);
        end
    endgenerate
    assign qstop_in = |qstop_hit;

    // source select, all in hundredths of percent of line speed
    always_comb begin
        case (src_r)
            MSR_SRC_KEYPAD: target = keypad_r;
            // analog and pulse levels clamped so a bad sensor stays in range
            MSR_SRC_VOLT_A: target =
                clamp14({2'b00, voltage_in_a}, `MSR_PCT_MAX);
            MSR_SRC_CURR_A: target =
                clamp14({2'b00, current_in_a}, `MSR_PCT_MAX);
            MSR_SRC_VOLT_B: target =
                clamp14({2'b00, voltage_in_b}, `MSR_PCT_MAX);
            MSR_SRC_CURR_B: target =
                clamp14({2'b00, current_in_b}, `MSR_PCT_MAX);
            MSR_SRC_SERIAL: target = tenths_to_pct(serial_in);
            MSR_SRC_ENCODER: target =
                clamp14({2'b00, encoder_in}, `MSR_PCT_MAX);
            MSR_SRC_FIELDBUS: target = tenths_to_pct(fieldbus_in);
            MSR_SRC_CONTROLLER: target = tenths_to_pct(controller_card_source);
            default: target = keypad_r;
        endcase
    end

    // settings written by software
    always_ff @(posedge mclk) begin
        if (rst) begin
            keypad_r <= `MSR_KEYPAD_RST;
            src_r <= MSR_SRC_VOLT_A;
            speed_ramp_enable_r <= 1'b0;
            speed_ramp_up_time_r <= `MSR_UP_TIME_RST;
            speed_ramp_down_time_r <= `MSR_DOWN_TIME_RST;
            qstop_time_r <= `MSR_QSTOP_TIME_RST;
            for (int i = 0; i < 8; i++) begin
                digital_input_function_r[i] <= 6'h00;
            end
        end else if (reg_wr) begin
            case (reg_addr)
                `MSR_ADDR_KEYPAD: keypad_r <= clamp14(reg_wdata, `MSR_PCT_MAX);
                `MSR_ADDR_SOURCE: begin
                    if (reg_wdata <= 16'(`MSR_SRC_MAX)) begin
                        src_r <= msr_src_t'(reg_wdata[3:0]);
                    end
                end
                `MSR_ADDR_RAMP_EN: speed_ramp_enable_r <= reg_wdata[0];
                `MSR_ADDR_UP_TIME: speed_ramp_up_time_r <=
                    12'(clamp14(reg_wdata, 14'(`MSR_TIME_MAX)));
                `MSR_ADDR_DOWN_TIME: speed_ramp_down_time_r <=
                    12'(clamp14(reg_wdata, 14'(`MSR_TIME_MAX)));
                `MSR_ADDR_QSTOP_TIME: begin
                    if (reg_wdata < 16'(`MSR_QSTOP_TIME_MIN)) begin
                        qstop_time_r <= `MSR_QSTOP_TIME_MIN;
                    end else begin
                        qstop_time_r <=
                            12'(clamp14(reg_wdata, 14'(`MSR_TIME_MAX)));
                    end
                end
                `MSR_ADDR_DIN_FUNC:
                    digital_input_function_r[reg_wdata[10:8]] <= reg_wdata[5:0];
                default: ;
            endcase
        end
    end

    // control tick generator
    always_ff @(posedge mclk) begin
        if (rst) begin
            tick_cnt_r <= 17'h00000;
            tick_r <= 1'b0;
        end else if (tick_cnt_r == 17'(TICK_CYC - 1)) begin
            tick_cnt_r <= 17'h00000;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 17'h00001;
            tick_r <= 1'b0;
        end
    end

    // run and quick stop state
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= MSR_ST_IDLE;
        end else begin
            case (state_r)
                MSR_ST_IDLE: begin
                    if (run_cmd) state_r <= MSR_ST_RUN;
                end
                MSR_ST_RUN: begin
                    if (!run_cmd) begin
                        state_r <= MSR_ST_IDLE;
                    end else if (qstop_in) begin
                        state_r <= MSR_ST_QSTOP;
                    end
                end
                // stays here until run drops; output is kept alive
                MSR_ST_QSTOP: begin
                    if (!run_cmd) state_r <= MSR_ST_IDLE;
                end
                default: state_r <= MSR_ST_IDLE;
            endcase
        end
    end

    // quick stop step: present output over the stop time, rounded up
    assign qstop_step = 30'(({16'h0, out_r} << `MSR_ACC_FRAC) /
        (32'(qstop_time_r) * `MSR_TICKS_PER_TENTH)) + 30'h1;

    // quick stop step latched from the output at entry
    always_ff @(posedge mclk) begin
        if (rst) begin
            step_q_r <= 30'h0;
        end else if (state_r == MSR_ST_RUN && run_cmd && qstop_in) begin
            step_q_r <= qstop_step;
        end
    end

    // one divider per direction, shared by compare and update
    assign up_step = step_of(speed_ramp_up_time_r);
    assign down_step = step_of(speed_ramp_down_time_r);
    assign target_acc = {target, 16'h0000};

    // ramp accumulator, 16 fraction bits
    always_ff @(posedge mclk) begin
        if (rst) begin
            acc_r <= 30'h0;
        end else if (state_r == MSR_ST_QSTOP) begin
            if (tick_r) begin
                acc_r <= (acc_r > step_q_r) ? acc_r - step_q_r : 30'h0;
            end
        end else if (!speed_ramp_enable_r) begin
            acc_r <= target_acc;
        end else if (tick_r) begin
            if (acc_r < target_acc) begin
                if (target_acc - acc_r > up_step)
                    acc_r <= acc_r + up_step;
                else acc_r <= target_acc;
            end else begin
                if (acc_r - target_acc > down_step)
                    acc_r <= acc_r - down_step;
                else acc_r <= target_acc;
            end
        end
    end
    assign out_r = acc_r[29:16];

    // registered outputs
    always_ff @(posedge mclk) begin
        if (rst) begin
            main_speed <= 14'h0000;
            main_speed_disp <= 14'h0000;
            drive_out_en <= 1'b0;
            tension_reg_en <= 1'b0;
            quick_stop_active <= 1'b0;
            tension_is_force <= 1'b0;
            tension_pct <= 14'h0000;
        end else begin
            main_speed <= out_r;
            main_speed_disp <= (state_r == MSR_ST_IDLE) ?
                target : out_r;
            drive_out_en <= (state_r != MSR_ST_IDLE);
            tension_reg_en <= (state_r != MSR_ST_IDLE);
            quick_stop_active <= (state_r == MSR_ST_QSTOP);
            tension_is_force <= closed_loop;
            tension_pct <= clamp14({2'b00, tension_cmd}, `MSR_PCT_MAX);
        end
    end

    // read port, data one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `MSR_ADDR_KEYPAD: reg_rdata <= {2'b00, keypad_r};
                `MSR_ADDR_SOURCE: reg_rdata <= {12'h000, src_r};
                `MSR_ADDR_RAMP_EN: reg_rdata <= {15'h0000, speed_ramp_enable_r};
                `MSR_ADDR_UP_TIME: reg_rdata <= {4'h0, speed_ramp_up_time_r};
                `MSR_ADDR_DOWN_TIME: reg_rdata <= {4'h0, speed_ramp_down_time_r};
                `MSR_ADDR_QSTOP_TIME: reg_rdata <= {4'h0, qstop_time_r};
                `MSR_ADDR_DISPLAY: reg_rdata <= {2'b00, main_speed_disp};
                `MSR_ADDR_STATUS: reg_rdata <= {12'h000, tension_is_force,
                    quick_stop_active, drive_out_en, speed_ramp_enable_r};
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule

/* bench/msr_ramp_properties.sv */
// checker: port timing relations of the speed ramp block
// assumes bind onto msr_ramp and a reset synchronous to mclk
`include "msr_map.svh"
module msr_ramp_properties (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_rdata,
    input wire logic run_cmd,
    input wire logic closed_loop,
    input wire logic [13:0] tension_cmd,
    input wire logic [13:0] main_speed,
    input wire logic [13:0] main_speed_disp,
    input wire logic drive_out_en,
    input wire logic tension_reg_en,
    input wire logic quick_stop_active,
    input wire logic tension_is_force,
    input wire logic [13:0] tension_pct
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // read port relations
    property p_disp_rd;
        reg_rd && reg_addr == `MSR_ADDR_DISPLAY
        |=> reg_rdata == {2'b00, $past(main_speed_disp)};
    endproperty
    a_disp_rd: assert property (p_disp_rd)
        else $error("display readback wrong");
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero without read");
    // output enables during run and quick stop, quick stop hold and falling speed
    property p_out_pair;
        tension_reg_en == drive_out_en;
    endproperty
    a_out_pair: assert property (p_out_pair)
        else $error("tension loop and output enable differ");
    property p_qs_out;
        quick_stop_active |-> drive_out_en;
    endproperty
    a_qs_out: assert property (p_qs_out)
        else $error("output dropped in quick stop");
    property p_qs_hold;
        quick_stop_active && run_cmd |=> quick_stop_active;
    endproperty
    a_qs_hold: assert property (p_qs_hold)
        else $error("quick stop left while running");
    property p_qs_down;
        quick_stop_active && $past(quick_stop_active)
        |-> main_speed <= $past(main_speed);
    endproperty
    a_qs_down: assert property (p_qs_down)
        else $error("speed rose in quick stop");
    // tension scaling and speed range
    property p_force;
        !$past(rst) |-> tension_is_force == $past(closed_loop);
    endproperty
    a_force: assert property (p_force)
        else $error("tension unit flag wrong");
    property p_pct;
        !$past(rst) |-> tension_pct == (($past(tension_cmd) > `MSR_PCT_MAX)
            ? `MSR_PCT_MAX : $past(tension_cmd));
    endproperty
    a_pct: assert property (p_pct)
        else $error("tension percent wrong");
    property p_speed_max;
        main_speed <= `MSR_PCT_MAX && main_speed_disp <= `MSR_PCT_MAX;
    endproperty
    a_speed_max: assert property (p_speed_max)
        else $error("speed above full scale");
    c_qs: cover property ($rose(quick_stop_active));
    c_run: cover property ($rose(drive_out_en));
    c_rd: cover property (reg_rd ##1 reg_rdata != 16'h0000);
endmodule
bind msr_ramp msr_ramp_properties u_props (.mclk(mclk), .rst(rst),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .run_cmd(run_cmd), .closed_loop(closed_loop),
    .tension_cmd(tension_cmd), .main_speed(main_speed),
    .main_speed_disp(main_speed_disp), .drive_out_en(drive_out_en),
    .tension_reg_en(tension_reg_en), .quick_stop_active(quick_stop_active),
    .tension_is_force(tension_is_force), .tension_pct(tension_pct));

/* bench/msr_line_src.sv */
// partner: line controller, sensors and network words feeding the selector
// assumes the bench picks the source; levels are steady
module msr_line_src (
    output logic [13:0] voltage_in_a,
    output logic [13:0] current_in_a,
    output logic [13:0] voltage_in_b,
    output logic [13:0] current_in_b,
    output logic [13:0] encoder_in,
    output logic [15:0] serial_in,
    output logic [15:0] fieldbus_in,
    output logic [15:0] controller_card_source
);
    timeunit 1ns;
    timeprecision 1ps;
    // steady commands, never stepped, hundredths for sensors
    assign voltage_in_a = 14'h03E8;
    assign current_in_a = 14'h07D0;
    assign voltage_in_b = 14'h0BB8;
    assign current_in_b = 14'h0FA0;
    assign encoder_in = 14'h1388;
    // network words in tenths of a percent
    assign serial_in = 16'h0258;
    assign fieldbus_in = 16'h00FA;
    assign controller_card_source = 16'h03E7;
endmodule

/* bench/main_speed_ramp_and_quick_stop_tb.sv */
// testbench: register access, source select, ramp, quick stop, tension
// assumes msr_ramp with 1 ms ticks, so no ramp tick lands in the run
`include "msr_map.svh"
module main_speed_ramp_and_quick_stop_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, run_cmd = 0;
    logic closed_loop = 0, drive_out_en, tension_reg_en;
    logic quick_stop_active, tension_is_force;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, ser, fb, cc, reg_rdata;
    logic [7:0] din = 8'h00;
    logic [13:0] tension_cmd = 14'h0000, va, ca, vb, cb, enc;
    logic [13:0] main_speed, main_speed_disp, tension_pct;
    int n_fail = 0, compares = 0;
    logic [15:0] exp_spd [0:8] = '{16'h04D2, 16'h03E8, 16'h07D0, 16'h0BB8,
        16'h0FA0, 16'h1770, 16'h1388, 16'h09C4, 16'h2706};
    logic [15:0] rst_val [0:5] = '{16'h0000, 16'h0001, 16'h0000, 16'h0064,
        16'h00C8, 16'h001E};
    msr_ramp u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .run_cmd(run_cmd), .din(din),
        .voltage_in_a(va), .current_in_a(ca), .voltage_in_b(vb),
        .current_in_b(cb), .encoder_in(enc), .serial_in(ser),
        .fieldbus_in(fb), .controller_card_source(cc),
        .closed_loop(closed_loop), .tension_cmd(tension_cmd),
        .main_speed(main_speed), .main_speed_disp(main_speed_disp),
        .drive_out_en(drive_out_en), .tension_reg_en(tension_reg_en),
        .quick_stop_active(quick_stop_active),
        .tension_is_force(tension_is_force), .tension_pct(tension_pct));
    msr_line_src u_src (.voltage_in_a(va), .current_in_a(ca),
        .voltage_in_b(vb), .current_in_b(cb), .encoder_in(enc),
        .serial_in(ser), .fieldbus_in(fb), .controller_card_source(cc));
    // clock and hang guard
    initial forever #5 mclk = ~mclk;
    initial begin
        #200000;
        n_fail++;
        $display("[FAIL] %0t run timed out", $time);
        print_verdict();
    end
    // shared compare, bus cycles and waits
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wait_qs(input logic v);
        int i;
        for (i = 0; i < 20 && quick_stop_active !== v; i++) wait_cycles(1);
        if (i == 20) begin
            n_fail++;
            $display("[FAIL] %0t quick stop flag wait ran out", $time);
            print_verdict();
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        for (int a = 0; a < 6; a++) rd(a[3:0], rst_val[a]);
        rd(4'h9, 16'h0000);
        $display("test reset values done");
        wr(`MSR_ADDR_KEYPAD, 16'h3000);
        rd(`MSR_ADDR_KEYPAD, 16'h2710);
        wr(`MSR_ADDR_SOURCE, 16'h0009);
        rd(`MSR_ADDR_SOURCE, 16'h0001);
        wr(`MSR_ADDR_UP_TIME, 16'h0FA0);
        rd(`MSR_ADDR_UP_TIME, 16'h0BB8);
        wr(`MSR_ADDR_SOURCE, 16'h0010);
        rd(`MSR_ADDR_SOURCE, 16'h0001);
        wr(`MSR_ADDR_DOWN_TIME, 16'hFFFF);
        rd(`MSR_ADDR_DOWN_TIME, 16'h0BB8);
        wr(`MSR_ADDR_QSTOP_TIME, 16'h1000);
        rd(`MSR_ADDR_QSTOP_TIME, 16'h0BB8);
        wr(`MSR_ADDR_QSTOP_TIME, 16'h0000);
        rd(`MSR_ADDR_QSTOP_TIME, 16'h0001);
        $display("test limits done");
        wr(`MSR_ADDR_KEYPAD, 16'h04D2);
        for (int s = 0; s < 9; s++) begin
            wr(`MSR_ADDR_SOURCE, 16'(s));
            wait_cycles(4);
            chk(16'(main_speed), exp_spd[s]);
        end
        $display("test sources done");
        wr(`MSR_ADDR_SOURCE, 16'h0000);
        run_cmd <= 1'b1;
        wr(`MSR_ADDR_RAMP_EN, 16'h0001);
        wr(`MSR_ADDR_SOURCE, 16'h0005);
        wait_cycles(10);
        chk({2'b00, main_speed}, 16'h04D2);
        rd(`MSR_ADDR_DISPLAY, 16'h04D2);
        @(posedge mclk);
        run_cmd <= 1'b0;
        wait_cycles(4);
        chk({2'b00, main_speed_disp}, 16'h1770);
        wr(`MSR_ADDR_RAMP_EN, 16'h0000);
        wait_cycles(4);
        chk({2'b00, main_speed}, 16'h1770);
        $display("test ramp and display done");
        wr(`MSR_ADDR_DIN_FUNC, 16'h0232);
        run_cmd <= 1'b1;
        din <= 8'h08;
        wait_cycles(6);
        chk({15'h0, quick_stop_active}, 16'h0000);
        @(posedge mclk);
        din <= 8'h04;
        wait_qs(1'b1);
        wait_cycles(10);
        chk({14'h0, drive_out_en, tension_reg_en}, 16'h0003);
        chk({15'h0, quick_stop_active}, 16'h0001);
        rd(`MSR_ADDR_STATUS, 16'h0006);
        @(posedge mclk);
        run_cmd <= 1'b0;
        din <= 8'h00;
        wait_qs(1'b0);
        wait_cycles(2);
        chk({15'h0, drive_out_en}, 16'h0000);
        $display("test quick stop done");
        @(posedge mclk);
        closed_loop <= 1'b1;
        tension_cmd <= 14'h0BB8;
        wait_cycles(2);
        chk({1'b0, tension_is_force, tension_pct}, 16'h4BB8);
        @(posedge mclk);
        closed_loop <= 1'b0;
        tension_cmd <= 14'h3FFF;
        wait_cycles(2);
        chk({1'b0, tension_is_force, tension_pct}, 16'h2710);
        $display("test tension done");
        print_verdict();
    end
endmodule
